// ===== rtl/ssf_pkg.sv
// Shared constants, carriers and state types for the socket present-state and force-event bank.
package ssf_pkg;

    // Bus geometry.
    localparam int unsigned SSF_AW = 8;
    localparam int unsigned SSF_DW = 32;

    // Register byte offsets; event and mask hold the interrupt status and its gate.
    localparam logic [SSF_AW-1:0] SSF_OFF_EVENT = 8'h00;
    localparam logic [SSF_AW-1:0] SSF_OFF_MASK = 8'h04;
    localparam logic [SSF_AW-1:0] SSF_OFF_PRESENT = 8'h08;
    localparam logic [SSF_AW-1:0] SSF_OFF_FORCE = 8'h0c;

    // Field positions shared by the present-state and force-event words.
    localparam int unsigned SSF_B_STATUS = 0;
    localparam int unsigned SSF_B_DET1 = 1;
    localparam int unsigned SSF_B_DET2 = 2;
    localparam int unsigned SSF_B_POWER = 3;
    localparam int unsigned SSF_B_SIXTEEN = 4;
    localparam int unsigned SSF_B_CARDBUS = 5;
    localparam int unsigned SSF_B_READY = 6;
    localparam int unsigned SSF_B_UNKNOWN = 7;
    localparam int unsigned SSF_B_LOSS = 8;
    localparam int unsigned SSF_B_BADREQ = 9;
    localparam int unsigned SSF_B_VOLT_LO = 10;
    localparam int unsigned SSF_B_VOLT_HI = 13;
    localparam int unsigned SSF_B_REINT = 14;
    localparam int unsigned SSF_B_SOCK_HIGH = 28;
    localparam int unsigned SSF_B_SOCK_LOW = 29;
    localparam int unsigned SSF_EV_W = 4;
    localparam int unsigned SSF_VOLT_W = 4;

    // Reset and fixed values.
    localparam logic [SSF_DW-1:0] SSF_ZERO_WORD = 32'h0000_0000;
    localparam logic [SSF_EV_W-1:0] SSF_EV_NONE = 4'h0;
    localparam logic [SSF_VOLT_W-1:0] SSF_VOLT_NONE = 4'h0;
    localparam logic [1:0] SSF_DET_BOTH = 2'h3;
    localparam logic [1:0] SSF_DET_NONE = 2'h0;

    // Interrogation time: a least time, so the cycle count rounds up.
    localparam int unsigned SSF_CLK_PS = 5000;
    localparam int unsigned SSF_INTERROG_NS = 1000;
    localparam int unsigned SSF_INTERROG_CYC = (SSF_INTERROG_NS * 1000 + SSF_CLK_PS - 1) / SSF_CLK_PS;
    localparam int unsigned SSF_CNT_W = 8;

    // Register port request.
    typedef struct packed {
        logic [SSF_AW-1:0] addr;
        logic [SSF_DW-1:0] wdata;
        logic we;
        logic re;
    } ssf_bus_req_s;

    // Socket pins, asynchronous to the bus clock.
    typedef struct packed {
        logic card_ready_irq_pin;
        logic card_status_change_pin;
        logic card_detect_pin_one;
        logic card_detect_pin_two;
    } ssf_pins_s;

    // Levels the socket pins show with no card seated; the synchroniser resets to these.
    localparam ssf_pins_s SSF_PINS_IDLE = '{card_ready_irq_pin: 1'b1, card_status_change_pin: 1'b0,
                                          card_detect_pin_one: 1'b1, card_detect_pin_two: 1'b1};

    // Result of the voltage-sense logic, valid when interrogation ends.
    typedef struct packed {
        logic cardbus;
        logic sixteen;
        logic unknown;
        logic [SSF_VOLT_W-1:0] volt;
    } ssf_sense_s;

    // Interrogation sequencer states.
    typedef enum logic [1:0] {
        SSF_IQ_IDLE = 2'b01,
        SSF_IQ_RUN = 2'b10
    } ssf_iq_e;

    // Whole state of the register bank.
    typedef struct packed {
        logic ready_irq_level;
        logic status_change_level;
        logic [1:0] pin_det_prev;
        logic cardbus_card_found;
        logic sixteen_bit_card_found;
        logic socket_power_state;
        logic detect_two_level;
        logic detect_one_level;
        logic [SSF_VOLT_W-1:0] volt_cap;
        logic invalid_supply_request;
        logic loss_on_removal;
        logic unrecognised_card;
        logic [SSF_EV_W-1:0] event_flags;
        logic [SSF_EV_W-1:0] irq_mask;
        logic [SSF_DW-1:0] rdata;
        logic irq;
        logic ctrl_en;
        logic start;
    } ssf_state_s;

endpackage

// ===== rtl/ssf_sync.sv
// Two-flop synchroniser for a group of asynchronous socket pins.
`timescale 1ns/1ps
`default_nettype none
module ssf_sync #(
    parameter int unsigned W = 4,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] async_i,
    output var logic [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } ssf_sync_s;

    ssf_sync_s st_q;
    ssf_sync_s st_d;

    // The first stage feeds only the second; nothing else looks at it.
    always_comb begin
        st_d.meta = async_i;
        st_d.stable = st_q.meta;
    end

    // Both stages reset to the idle pin levels, so no false edge follows reset.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_q <= '{meta: RST_VAL, stable: RST_VAL};
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_o = st_q.stable;
endmodule // ssf_sync
`default_nettype wire

// ===== rtl/ssf_interrog.sv
// Card interrogation sequencer: holds busy for a fixed time after the last start, then pulses done.
`timescale 1ns/1ps
`default_nettype none
module ssf_interrog
    import ssf_pkg::*;
#(
    parameter int unsigned CYCLES = SSF_INTERROG_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    output var logic busy_o,
    output var logic done_o
);
    typedef struct packed {
        ssf_iq_e st;
        logic [SSF_CNT_W-1:0] cnt;
        logic busy;
        logic done;
    } ssf_iq_s;

    localparam logic [SSF_CNT_W-1:0] LAST = SSF_CNT_W'(CYCLES - 1);

    ssf_iq_s st_q;
    ssf_iq_s st_d;

    // A start while running restarts the count, so a late trigger is never dropped.
    always_comb begin
        st_d = st_q;
        st_d.done = 1'b0;
        case (st_q.st)
            SSF_IQ_IDLE: begin
                if (start_i) begin
                    st_d.st = SSF_IQ_RUN;
                    st_d.cnt = '0;
                    st_d.busy = 1'b1;
                end
            end
            SSF_IQ_RUN: begin
                if (start_i) begin
                    st_d.cnt = '0;
                end else if (st_q.cnt == LAST) begin
                    st_d.st = SSF_IQ_IDLE;
                    st_d.busy = 1'b0;
                    st_d.done = 1'b1;
                end else begin
                    st_d.cnt = st_q.cnt + 1'b1;
                end
            end
            default: begin
                st_d.st = SSF_IQ_IDLE;
                st_d.busy = 1'b0;
            end
        endcase
    end

    // Sequencer register.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_q <= '{st: SSF_IQ_IDLE, cnt: '0, busy: 1'b0, done: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign busy_o = st_q.busy;
    assign done_o = st_q.done;
endmodule // ssf_interrog
`default_nettype wire

// ===== rtl/ssf_bank.sv
// Socket present-state and force-event register bank with event interrupt.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module ssf_bank
    import ssf_pkg::*;
#(
    parameter int unsigned INTERROG_CYCLES = SSF_INTERROG_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire ssf_bus_req_s bus_i,
    output var logic [SSF_DW-1:0] rdata_o,
    input wire ssf_pins_s pins_i,
    input wire logic power_up_i,
    input wire ssf_sense_s sense_i,
    output var logic irq_o,
    output var logic socket_ctrl_en_o,
    output var logic interrog_busy_o
);
    ssf_state_s st_q;
    ssf_state_s st_d;
    ssf_pins_s pins_s;
    logic iq_busy;
    logic iq_done;

    // True when the request address matches a register offset.
    function automatic logic hit(input logic [SSF_AW-1:0] addr, input logic [SSF_AW-1:0] off);
        hit = (addr == off);
    endfunction

    // Mask as applied: the detect pair only opens when both bits are set.
    function automatic logic [SSF_EV_W-1:0] eff_mask(input logic [SSF_EV_W-1:0] m);
        logic both;
        both = (m[SSF_B_DET2:SSF_B_DET1] == SSF_DET_BOTH);
        eff_mask = m;
        eff_mask[SSF_B_DET1] = both;
        eff_mask[SSF_B_DET2] = both;
    endfunction

    // Assembles the present-state word from the held fields.
    function automatic logic [SSF_DW-1:0] present_word(input ssf_state_s s);
        logic [SSF_DW-1:0] w;
        w = SSF_ZERO_WORD;
        w[SSF_B_SOCK_LOW] = 1'b1;
        w[SSF_B_SOCK_HIGH] = 1'b1;
        w[SSF_B_VOLT_HI:SSF_B_VOLT_LO] = s.volt_cap;
        w[SSF_B_BADREQ] = s.invalid_supply_request;
        w[SSF_B_LOSS] = s.loss_on_removal;
        w[SSF_B_UNKNOWN] = s.unrecognised_card;
        w[SSF_B_READY] = s.ready_irq_level;
        w[SSF_B_CARDBUS] = s.cardbus_card_found;
        w[SSF_B_SIXTEEN] = s.sixteen_bit_card_found;
        w[SSF_B_POWER] = s.socket_power_state;
        w[SSF_B_DET2] = s.detect_two_level;
        w[SSF_B_DET1] = s.detect_one_level;
        w[SSF_B_STATUS] = s.status_change_level;
        present_word = w;
    endfunction

    // Socket pins come from outside the bus clock domain.
    ssf_sync #(
        .W($bits(ssf_pins_s)),
        .RST_VAL(SSF_PINS_IDLE)
    ) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .async_i(pins_i),
        .sync_o(pins_s)
    );

    // Interrogation timing; the type sensing itself happens outside.
    ssf_interrog #(
        .CYCLES(INTERROG_CYCLES)
    ) u_interrog (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .start_i(st_q.start),
        .busy_o(iq_busy),
        .done_o(iq_done)
    );

    // Next-state logic: pin tracking, interrogation results, force writes, events and readback.
    always_comb begin
        logic wr_force;
        logic rd_event;
        logic insert;
        logic [SSF_EV_W-1:0] ev_set;
        logic [SSF_DW-1:0] wd;
        wr_force = 1'b0;
        rd_event = 1'b0;
        insert = 1'b0;
        ev_set = SSF_EV_NONE;
        wd = bus_i.wdata;
        st_d = st_q;
        st_d.start = 1'b0;

        // Live pin levels.
        st_d.ready_irq_level = pins_s.card_ready_irq_pin;
        st_d.status_change_level = pins_s.card_status_change_pin;
        st_d.pin_det_prev = {pins_s.card_detect_pin_two, pins_s.card_detect_pin_one};

        // A card goes in when the detect pins first read both low, whichever of them fell last.
        insert = (st_d.pin_det_prev == SSF_DET_NONE) && (st_q.pin_det_prev != SSF_DET_NONE);

        // Detect bits hold still while the card is being interrogated.
        if (!iq_busy) begin
            st_d.detect_one_level = pins_s.card_detect_pin_one;
            st_d.detect_two_level = pins_s.card_detect_pin_two;
        end
        st_d.socket_power_state = power_up_i;

        // Hardware events, raised on each change of the tracked level.
        ev_set[SSF_B_STATUS] = st_q.status_change_level != st_d.status_change_level;
        ev_set[SSF_B_DET1] = st_q.detect_one_level != st_d.detect_one_level;
        ev_set[SSF_B_DET2] = st_q.detect_two_level != st_d.detect_two_level;
        ev_set[SSF_B_POWER] = st_q.socket_power_state != st_d.socket_power_state;

        // Card type and voltage capability change only when interrogation finishes or on a force write.
        if (iq_done) begin
            st_d.cardbus_card_found = sense_i.cardbus;
            st_d.sixteen_bit_card_found = sense_i.sixteen;
            st_d.unrecognised_card = sense_i.unknown;
            st_d.volt_cap = sense_i.volt;
            st_d.ctrl_en = 1'b1;
        end

        // Register writes; the force register holds nothing, it only acts.
        if (bus_i.we) begin
            if (hit(bus_i.addr, SSF_OFF_MASK)) begin
                st_d.irq_mask = wd[SSF_EV_W-1:0];
            end else if (hit(bus_i.addr, SSF_OFF_FORCE)) begin
                wr_force = 1'b1;
            end
        end

        // A forced value written in the same cycle as a finishing interrogation wins.
        if (wr_force) begin
            st_d.volt_cap = wd[SSF_B_VOLT_HI:SSF_B_VOLT_LO];
            st_d.invalid_supply_request = wd[SSF_B_BADREQ];
            st_d.loss_on_removal = wd[SSF_B_LOSS];
            st_d.unrecognised_card = wd[SSF_B_UNKNOWN];
            st_d.cardbus_card_found = wd[SSF_B_CARDBUS];
            st_d.sixteen_bit_card_found = wd[SSF_B_SIXTEEN];
            if (|wd[SSF_B_VOLT_HI:SSF_B_VOLT_LO]) begin
                st_d.ctrl_en = 1'b0;
            end
        end

        // Start interrogation on insertion or on the trigger bit.
        if (insert || (wr_force && wd[SSF_B_REINT])) begin
            st_d.start = 1'b1;
        end

        // Reads: readback one cycle later; reading the event word clears it.
        st_d.rdata = SSF_ZERO_WORD;
        if (bus_i.re) begin
            if (hit(bus_i.addr, SSF_OFF_EVENT)) begin
                st_d.rdata[SSF_EV_W-1:0] = st_q.event_flags;
                rd_event = 1'b1;
            end else if (hit(bus_i.addr, SSF_OFF_MASK)) begin
                st_d.rdata[SSF_EV_W-1:0] = st_q.irq_mask;
            end else if (hit(bus_i.addr, SSF_OFF_PRESENT)) begin
                st_d.rdata = present_word(st_q);
            end else begin
                st_d.rdata = SSF_ZERO_WORD;
            end
        end

        // Event flags: clear by read, load by force, hardware set always wins.
        st_d.event_flags = st_q.event_flags;
        if (rd_event) begin
            st_d.event_flags = SSF_EV_NONE;
        end
        if (wr_force) begin
            st_d.event_flags = wd[SSF_EV_W-1:0];
        end
        st_d.event_flags = st_d.event_flags | ev_set;

        // Level interrupt from any unmasked pending flag.
        st_d.irq = |(st_d.event_flags & eff_mask(st_d.irq_mask));
    end

    // Single state register; detect bits start at the no-card level.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
            st_q.pin_det_prev <= SSF_DET_BOTH;
            st_q.detect_one_level <= 1'b1;
            st_q.detect_two_level <= 1'b1;
            st_q.ctrl_en <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata_o = st_q.rdata;
    assign irq_o = st_q.irq;
    assign socket_ctrl_en_o = st_q.ctrl_en;
    assign interrog_busy_o = iq_busy;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    logic force_wr;
    assign force_wr = bus_i.we && (bus_i.addr == SSF_OFF_FORCE);

    ready_live_a: assert property (
        bus_i.re && (bus_i.addr == SSF_OFF_PRESENT) |=> rdata_o[SSF_B_READY] == $past(st_q.ready_irq_level))
        else $error("Ready level readback wrong.");

    status_live_a: assert property (
        $changed(pins_s.card_status_change_pin) |=> st_q.status_change_level == $past(pins_s.card_status_change_pin))
        else $error("Status-change level not tracked.");

    type_hold_a: assert property (
        !force_wr && !iq_done |=> $stable(st_q.cardbus_card_found) && $stable(st_q.sixteen_bit_card_found))
        else $error("Card type changed without interrogation or force.");

    power_track_a: assert property (
        $rose(power_up_i) |=> st_q.socket_power_state && st_q.event_flags[SSF_B_POWER])
        else $error("Power state or event missing.");

    detect_freeze_a: assert property (
        iq_busy |=> $stable(st_q.detect_one_level) && $stable(st_q.detect_two_level))
        else $error("Detect bits moved during interrogation.");

    reint_start_a: assert property (
        force_wr && bus_i.wdata[SSF_B_REINT] |-> ##[2:3] iq_busy)
        else $error("Trigger did not start interrogation.");

    volt_load_a: assert property (
        force_wr && !bus_i.wdata[SSF_B_REINT] |=> st_q.volt_cap == $past(bus_i.wdata[SSF_B_VOLT_HI:SSF_B_VOLT_LO]))
        else $error("Voltage capability not loaded.");

    ctrl_off_a: assert property (
        force_wr && (|bus_i.wdata[SSF_B_VOLT_HI:SSF_B_VOLT_LO]) |=> !socket_ctrl_en_o)
        else $error("Socket control not disabled.");

    flags_load_a: assert property (
        force_wr |=> st_q.invalid_supply_request == $past(bus_i.wdata[SSF_B_BADREQ])
            && st_q.loss_on_removal == $past(bus_i.wdata[SSF_B_LOSS]))
        else $error("Forced flag not loaded.");

    event_force_a: assert property (
        force_wr && bus_i.wdata[SSF_B_DET1] |=> st_q.event_flags[SSF_B_DET1] ##1 irq_o == |(st_q.event_flags
            & eff_mask(st_q.irq_mask)))
        else $error("Forced event not loaded.");

    force_zero_a: assert property (
        bus_i.re && (bus_i.addr == SSF_OFF_FORCE) |=> rdata_o == SSF_ZERO_WORD)
        else $error("Force register read not zero.");

    detect_mask_a: assert property (
        irq_o && (st_q.event_flags & ~(SSF_EV_W'(1) << SSF_B_DET1) & ~(SSF_EV_W'(1) << SSF_B_DET2)
            & st_q.irq_mask) == SSF_EV_NONE |-> st_q.irq_mask[SSF_B_DET2:SSF_B_DET1] == SSF_DET_BOTH)
        else $error("Interrupt from detect without full mask pair.");
endmodule // ssf_bank
`default_nettype wire

// ===== testbench/ssf_card_model.sv
// Behavioural card in the socket: detect, ready and status pins, supply switch and voltage sense.
`timescale 1ns/1ps
`default_nettype none
module ssf_card_model
    import ssf_pkg::*;
#(
    parameter logic [SSF_VOLT_W-1:0] CARD_VOLT = 4'h6
) (
    input wire logic clk_i,
    input wire logic inserted_i,
    input wire logic ready_i,
    input wire logic status_i,
    input wire logic lift_one_i,
    input wire logic power_req_i,
    output var ssf_pins_s pins_o,
    output var logic power_up_o,
    output var ssf_sense_s sense_o
);
    logic [2:0] supply_q = 3'h0;

    // The supply switch answers three cycles late, so the bank never sees an instant result.
    always_ff @(posedge clk_i) begin
        supply_q <= {supply_q[1:0], power_req_i};
    end
    assign power_up_o = supply_q[2];

    // An empty socket leaves the pulled-up pins high and the pulled-down status pin low.
    always_comb begin
        pins_o.card_detect_pin_one = ~inserted_i | lift_one_i;
        pins_o.card_detect_pin_two = ~inserted_i;
        pins_o.card_ready_irq_pin = inserted_i ? ready_i : 1'b1;
        pins_o.card_status_change_pin = inserted_i & status_i;
    end

    // Voltage sense reports a CardBus card only while one is seated.
    always_comb begin
        sense_o = '0;
        if (inserted_i) begin
            sense_o.cardbus = 1'b1;
            sense_o.volt = CARD_VOLT;
        end
    end
endmodule // ssf_card_model
`default_nettype wire

// ===== testbench/ssf_bank_tb.sv
// Self-checking testbench for the socket present-state and force-event bank.
`timescale 1ns/1ps
`default_nettype none
module ssf_bank_tb
    import ssf_pkg::*;
;
    localparam int unsigned IQ_CYC = 16;
    localparam logic [3:0] CARD_VOLT = 4'h6;
    logic clk;
    logic rst_n;
    ssf_bus_req_s bus;
    logic [31:0] rdata;
    ssf_pins_s pins;
    logic power_up;
    ssf_sense_s sense;
    logic irq;
    logic ctrl_en;
    logic busy;
    logic ins, rdy, sts, lift, pwr;
    logic [31:0] d;
    int err_total;
    int cmp_count;

    ssf_bank #(.INTERROG_CYCLES(IQ_CYC)) u_ssf_bank (
        .clk_i(clk), .rst_n_i(rst_n), .bus_i(bus), .rdata_o(rdata), .pins_i(pins),
        .power_up_i(power_up), .sense_i(sense), .irq_o(irq), .socket_ctrl_en_o(ctrl_en),
        .interrog_busy_o(busy));

    ssf_card_model #(.CARD_VOLT(CARD_VOLT)) u_ssf_card_model (
        .clk_i(clk), .inserted_i(ins), .ready_i(rdy), .status_i(sts), .lift_one_i(lift),
        .power_req_i(pwr), .pins_o(pins), .power_up_o(power_up), .sense_o(sense));

    // Free-running 200 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Prints the counts and the verdict, then stops the run.
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Bus cycles: one strobe cycle; read data are taken in the cycle after the read strobe.
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= w;
        bus.we <= 1'b1;
        @(posedge clk);
        bus.we <= 1'b0;
        #1;
    endtask

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] r);
        @(posedge clk);
        bus.addr <= a;
        bus.re <= 1'b1;
        @(posedge clk);
        bus.re <= 1'b0;
        #1;
        r = rdata;
    endtask

    // Bounded wait on the interrogation flag; running out ends the run.
    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (busy !== lvl && n < 64) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (busy !== lvl) begin
            err_total++;
            $display("wrong value at %0t ns: interrogation wait ran out", $time);
            give_verdict();
        end
    endtask

    // Interrupt is checked two edges on, so a registered mask change has landed.
    task automatic irq_is(input logic exp, input string what);
        repeat (2) @(posedge clk);
        #1;
        check(32'(irq), 32'(exp), what);
    endtask

    // Present word from the pin levels the model is showing.
    function automatic logic [31:0] live();
        logic [31:0] w;
        w = 32'h3000_0000;
        w[SSF_B_READY] = ins ? rdy : 1'b1;
        w[SSF_B_POWER] = pwr;
        w[SSF_B_DET2] = ~ins;
        w[SSF_B_DET1] = ~ins | lift;
        w[SSF_B_STATUS] = ins & sts;
        return w;
    endfunction

    function automatic logic [31:0] cardw();
        return (32'(CARD_VOLT) << SSF_B_VOLT_LO) | (32'h1 << SSF_B_CARDBUS);
    endfunction

    task automatic t_reset();
        repeat (4) @(posedge clk);
        bus_rd(SSF_OFF_PRESENT, d);
        check(d, live(), "present after reset");
        bus_rd(8'h40, d);
        check(d, 32'h0, "unmapped read");
        $display("test reset done");
    endtask

    task automatic t_insert();
        @(posedge clk);
        ins <= 1'b1;
        wait_busy(1'b1);
        wait_busy(1'b0);
        repeat (2) @(posedge clk);
        bus_rd(SSF_OFF_PRESENT, d);
        check(d, live() | cardw(), "present after insertion");
        $display("test insert done");
    endtask

    task automatic t_live();
        for (int i = 1; i >= 0; i--) begin
            @(posedge clk);
            rdy <= 1'(i);
            sts <= 1'(i);
            repeat (5) @(posedge clk);
            bus_rd(SSF_OFF_PRESENT, d);
            check(d, live() | cardw(), "ready and status pins");
        end
        $display("test live pins done");
    endtask

    task automatic t_power();
        bus_rd(SSF_OFF_EVENT, d);
        @(posedge clk);
        pwr <= 1'b1;
        repeat (8) @(posedge clk);
        bus_rd(SSF_OFF_PRESENT, d);
        check(d, live() | cardw(), "powered up");
        bus_rd(SSF_OFF_EVENT, d);
        check(d, 32'h8, "power event flag");
        $display("test power done");
    endtask

    task automatic t_force();
        bus_wr(SSF_OFF_FORCE, 32'h0000_2b90);
        bus_wr(8'h40, 32'hffff_ffff);
        bus_rd(SSF_OFF_PRESENT, d);
        check(d, live() | 32'h0000_2b90, "forced present");
        check(32'(ctrl_en), 32'h0, "control disabled");
        bus_rd(SSF_OFF_FORCE, d);
        check(d, 32'h0, "force reads zero");
        bus_rd(SSF_OFF_EVENT, d);
        bus_wr(SSF_OFF_FORCE, 32'h0000_000f);
        bus_rd(SSF_OFF_EVENT, d);
        check(d, 32'hf, "forced events");
        bus_rd(SSF_OFF_PRESENT, d);
        check(d, live(), "present low bits kept");
        $display("test force done");
    endtask

    task automatic t_reint();
        bus_wr(SSF_OFF_FORCE, 32'h0000_4000);
        wait_busy(1'b1);
        @(posedge clk);
        lift <= 1'b1;
        repeat (5) @(posedge clk);
        bus_rd(SSF_OFF_PRESENT, d);
        check(32'(d[SSF_B_DET1]), 32'h0, "detect one frozen");
        wait_busy(1'b0);
        repeat (2) @(posedge clk);
        check(32'(ctrl_en), 32'h1, "control enabled again");
        bus_rd(SSF_OFF_PRESENT, d);
        check(d, live() | cardw(), "present refreshed");
        $display("test reinterrogate done");
    endtask

    task automatic t_irq();
        bus_rd(SSF_OFF_EVENT, d);
        bus_wr(SSF_OFF_MASK, 32'h1);
        bus_wr(SSF_OFF_FORCE, 32'h1);
        irq_is(1'b1, "unmasked status event");
        bus_wr(SSF_OFF_FORCE, 32'h2);
        irq_is(1'b0, "masked detect event");
        bus_wr(SSF_OFF_MASK, 32'h2);
        irq_is(1'b0, "half detect mask");
        bus_wr(SSF_OFF_MASK, 32'h6);
        irq_is(1'b1, "full detect mask");
        bus_rd(SSF_OFF_EVENT, d);
        check(d, 32'h2, "event read");
        irq_is(1'b0, "cleared by read");
        $display("test interrupt done");
    endtask

    // Main sequence: reset for six cycles, then each scenario in turn.
    initial begin
        err_total = 0;
        cmp_count = 0;
        bus = '0;
        rst_n = 1'b0;
        ins = 1'b0;
        rdy = 1'b0;
        sts = 1'b0;
        lift = 1'b0;
        pwr = 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_insert();
        t_live();
        t_power();
        t_force();
        t_reint();
        t_irq();
        give_verdict();
    end
endmodule // ssf_bank_tb
`default_nettype wire
